// ---- pbra_pkg.sv ----
// Package for the peripheral bus register access block: port decodes, field layouts, reset values.
// Assumes a single 100 MHz core clock and a synchronous active-low reset.
package pbra_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;

	// Latched I/O port decodes (10-bit address)
	localparam logic [9:0] PORT_IRQ_CMD = 10'h020;
	localparam logic [9:0] PORT_IRQ_MASK = 10'h021;
	localparam logic [9:0] PORT_TMR_CH0 = 10'h040;
	localparam logic [9:0] PORT_TMR_CH2 = 10'h042;
	localparam logic [9:0] PORT_TMR_CH3 = 10'h044;
	localparam logic [9:0] PORT_TMR_CTRL = 10'h043;
	localparam logic [9:0] PORT_SYS_B = 10'h061;
	localparam logic [9:0] PORT_RTC_ADDR = 10'h070;
	localparam logic [9:0] PORT_RTC_DATA = 10'h071;
	localparam logic [9:0] PORT_SYS_A = 10'h092;
	localparam logic [9:0] PORT_SETUP = 10'h094;
	localparam logic [9:0] PORT_CHAN_POS = 10'h096;
	localparam logic [9:0] PORT_CFG = 10'h102;

	// Read-back forcing masks, write mask and watchdog bit position
	localparam logic [7:0] SYS_A_RD_ONES = 8'h24;
	localparam logic [7:0] CHAN_POS_RD_ONES = 8'h70;
	localparam logic [7:0] CHAN_POS_WR_MASK = 8'h8f;
	localparam int unsigned SYS_A_WDT_BIT = 4;

	// Reset values, idle byte, vector base, timekeeping memory depth and address width
	localparam logic [7:0] SYS_B_RST = 8'h00;
	localparam logic [7:0] SYS_A_RST = 8'h00;
	localparam logic [7:0] SETUP_RST = 8'h80;
	localparam logic [7:0] CHAN_POS_RST = 8'h00;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] IRQ_VECTOR_BASE = 8'h08;
	localparam int unsigned RTC_DEPTH = 64;
	localparam int unsigned RTC_AW = 6;

	// Bus cycle kinds
	typedef enum logic [1:0] {
		PBRA_IDLE = 2'b00,
		PBRA_READ = 2'b01,
		PBRA_ACK = 2'b11,
		PBRA_WRITE = 2'b10
	} pbra_cycle_t;

endpackage : pbra_pkg

// ---- pbra_mem_if.sv ----
// Interface carrying the timekeeping RAM access between the bus port and its memory.
// Assumes both ends run on the core clock.
interface pbra_mem_if;
	logic we;
	logic [5:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	modport ctrl (output we, output addr, output wdata, input rdata);
	modport mem (input we, input addr, input wdata, output rdata);
endinterface : pbra_mem_if

// ---- pbra_rtc_mem.sv ----
// Small register-output memory backing the timekeeping registers.
// Assumes the controller presents address and write data on the core clock.
module pbra_rtc_mem (
	// Clock
	input wire logic core_clk_i,
	// Access
	pbra_mem_if.mem bus
);

	logic [7:0] mem_reg [pbra_pkg::RTC_DEPTH];
	logic [7:0] rdata_reg;

	// No reset here: timekeeping contents must survive a logic reset
	always_ff @(posedge core_clk_i)
	begin
		if (bus.we)
		begin
			mem_reg[bus.addr] <= bus.wdata;
		end
		rdata_reg <= mem_reg[bus.addr];
	end

	assign bus.rdata = rdata_reg;

endmodule : pbra_rtc_mem

// ---- pbra_port.sv ----
// Peripheral bus port of the system peripheral controller: address latch, decode, data steering.
// Assumes all bus pins are asynchronous to core_clk_i and are synchronised here.
// How it works
// - Drive data bus only on internal reads and interrupt acknowledges
// - Interrupt, timer, timekeeping, configuration registers readable
// - Ports 61, 92, 96, 102 return data
// - Writes release drivers and capture data
// - Acknowledge places interrupt vector on bus
// - Data bus multiplexes timekeeping address/data
// - Address latch strobe captures ten lines
// - Qualified latch strobe clears parallel interrupt
// - Logic reset spares timekeeping memory; the index register is cleared
// - Read command drives addressed register out
// - Write command stores into latched register
// - External master reaches interrupt registers only
// - Master indication blocks non-interrupt decodes
// - Upper address zero qualifies all decodes
module pbra_port (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic logic_reset_input_i,
	// Peripheral bus
	input wire logic [7:0] peripheral_data_bus_i,
	output logic [7:0] peripheral_data_bus_o,
	output logic peripheral_data_bus_oe_o,
	input wire logic [9:0] latched_peripheral_address_i,
	input wire logic [5:0] upper_address_i,
	input wire logic address_latch_strobe_n_i,
	input wire logic io_read_cmd_n_i,
	input wire logic io_write_cmd_n_i,
	input wire logic irq_ack_n_i,
	input wire logic ext_master_n_i,
	// Status from neighbouring functions
	input wire logic [7:0] irq_request_i,
	input wire logic [7:0] irq_in_service_i,
	input wire logic [7:0] tmr_ch0_i,
	input wire logic [7:0] tmr_ch2_i,
	input wire logic [7:0] tmr_ch3_i,
	input wire logic [2:0] irq_level_i,
	input wire logic wdt_timeout_i,
	// Decoded outputs
	output logic onboard_peripheral_select_n_o,
	output logic qualified_latch_strobe_n_o,
	output logic par_irq_clear_o,
	output logic [7:0] irq_mask_o,
	output logic [7:0] sys_b_o,
	output logic [7:0] sys_a_o,
	output logic [7:0] setup_o,
	output logic [7:0] chan_pos_o,
	output logic [7:0] cfg_o
);

	typedef struct packed {
		logic [1:0] strb_s1;
		logic [1:0] strb_s2;
		logic [1:0] cmd_s1;
		logic [1:0] cmd_s2;
		logic ack_s1;
		logic ack_s2;
		logic mst_s1;
		logic mst_s2;
		logic [7:0] din_s1;
		logic [7:0] din_s2;
		logic [9:0] adr_s1;
		logic [9:0] adr_s2;
		logic [5:0] up_s1;
		logic [5:0] up_s2;
		logic strb_d;
		logic ack_d;
		logic wr_d;
		logic ack_cnt;
		logic [9:0] addr;
		logic onboard_peripheral_select_n_n;
		logic qstrb_n;
		logic par_clr;
		pbra_pkg::pbra_cycle_t cyc;
		logic [7:0] dout;
		logic oe;
		logic [7:0] mask;
		logic [7:0] sys_b;
		logic [7:0] sys_a;
		logic [7:0] setup;
		logic [7:0] chan_pos;
		logic [7:0] cfg;
		logic [5:0] rtc_idx;
		logic [7:0] tmr_ctl;
		logic lrst_s1;
		logic lrst_s2;
	} pbra_state_t;

	pbra_state_t st_reg;
	pbra_state_t st_next;
	pbra_mem_if rtc_bus ();

	pbra_rtc_mem u_rtc_mem (
		.core_clk_i(core_clk_i),
		.bus(rtc_bus.mem)
	);

	// True when the latched port belongs to the interrupt controller
	function automatic logic is_irq_port(input logic [9:0] a);
		is_irq_port = (a == pbra_pkg::PORT_IRQ_CMD) || (a == pbra_pkg::PORT_IRQ_MASK);
	endfunction : is_irq_port

	// Only decoded ports answer a read; any other port leaves the bus to others
	function automatic logic is_mapped(input logic [9:0] a);
		is_mapped = is_irq_port(a) || (a inside {pbra_pkg::PORT_TMR_CH0, pbra_pkg::PORT_TMR_CH2,
			pbra_pkg::PORT_TMR_CH3, pbra_pkg::PORT_TMR_CTRL, pbra_pkg::PORT_SYS_B,
			pbra_pkg::PORT_RTC_ADDR, pbra_pkg::PORT_RTC_DATA, pbra_pkg::PORT_SYS_A,
			pbra_pkg::PORT_SETUP, pbra_pkg::PORT_CHAN_POS, pbra_pkg::PORT_CFG});
	endfunction : is_mapped

	logic rd;
	logic wr;
	logic both;
	logic sel;
	logic own;
	logic irq_hit;
	logic rtc_data_hit;
	logic [7:0] rd_mux;

	always_comb
	begin
		st_next = st_reg;
		// Second stage only feeds logic; first stage is read by nothing else
		st_next.strb_s1 = {address_latch_strobe_n_i, 1'b0};
		st_next.strb_s2 = st_reg.strb_s1;
		st_next.cmd_s1 = {io_read_cmd_n_i, io_write_cmd_n_i};
		st_next.cmd_s2 = st_reg.cmd_s1;
		st_next.ack_s1 = irq_ack_n_i;
		st_next.ack_s2 = st_reg.ack_s1;
		st_next.mst_s1 = ext_master_n_i;
		st_next.mst_s2 = st_reg.mst_s1;
		st_next.din_s1 = peripheral_data_bus_i;
		st_next.din_s2 = st_reg.din_s1;
		st_next.adr_s1 = latched_peripheral_address_i;
		st_next.adr_s2 = st_reg.adr_s1;
		st_next.up_s1 = upper_address_i;
		st_next.up_s2 = st_reg.up_s1;
		// Logic reset pin is asynchronous, so it is synchronised like the others
		st_next.lrst_s1 = logic_reset_input_i;
		st_next.lrst_s2 = st_reg.lrst_s1;

		rd = !st_reg.cmd_s2[1];
		wr = !st_reg.cmd_s2[0];
		both = rd && wr;
		st_next.strb_d = st_reg.strb_s2[1];
		st_next.ack_d = st_reg.ack_s2;
		st_next.wr_d = wr && !both;

		// Latch follows the strobe while it is low, holds afterwards
		if (!st_reg.strb_s2[1])
		begin
			st_next.addr = st_reg.adr_s2;
			st_next.onboard_peripheral_select_n_n = (st_reg.up_s2 != 6'h00);
		end
		st_next.qstrb_n = st_reg.strb_s2[1] || st_next.onboard_peripheral_select_n_n;
		st_next.par_clr = st_reg.strb_d && !st_reg.strb_s2[1] && !st_next.onboard_peripheral_select_n_n;

		irq_hit = is_irq_port(st_reg.addr);
		sel = !st_reg.onboard_peripheral_select_n_n;
		// Master blocks all but interrupt decodes
		own = sel && (irq_hit || st_reg.mst_s2);
		rtc_data_hit = own && (st_reg.addr == pbra_pkg::PORT_RTC_DATA);

		unique case (st_reg.addr)
			pbra_pkg::PORT_IRQ_CMD: rd_mux = st_reg.tmr_ctl[0] ? irq_in_service_i : irq_request_i;
			pbra_pkg::PORT_IRQ_MASK: rd_mux = st_reg.mask;
			pbra_pkg::PORT_TMR_CH0: rd_mux = tmr_ch0_i;
			pbra_pkg::PORT_TMR_CH2: rd_mux = tmr_ch2_i;
			pbra_pkg::PORT_TMR_CH3: rd_mux = tmr_ch3_i;
			pbra_pkg::PORT_TMR_CTRL: rd_mux = st_reg.tmr_ctl;
			pbra_pkg::PORT_SYS_B: rd_mux = st_reg.sys_b;
			pbra_pkg::PORT_RTC_ADDR: rd_mux = {2'b00, st_reg.rtc_idx};
			pbra_pkg::PORT_RTC_DATA: rd_mux = rtc_bus.rdata;
			pbra_pkg::PORT_SYS_A: rd_mux = (st_reg.sys_a | pbra_pkg::SYS_A_RD_ONES)
				| ({7'h00, wdt_timeout_i} << pbra_pkg::SYS_A_WDT_BIT);
			pbra_pkg::PORT_SETUP: rd_mux = st_reg.setup;
			pbra_pkg::PORT_CHAN_POS: rd_mux = st_reg.chan_pos | pbra_pkg::CHAN_POS_RD_ONES;
			pbra_pkg::PORT_CFG: rd_mux = st_reg.cfg;
			default: rd_mux = pbra_pkg::BYTE_ZERO;
		endcase

		// The end of the first pulse arms; the second pulse carries the vector
		// A lone pulse leaves the count armed until the next one arrives
		if (!st_reg.ack_d && st_reg.ack_s2)
		begin
			st_next.ack_cnt = !st_reg.ack_cnt;
		end

		if (both)
		begin
			st_next.cyc = pbra_pkg::PBRA_IDLE;
		end
		else if (!st_reg.ack_s2 && st_reg.ack_cnt)
		begin
			st_next.cyc = pbra_pkg::PBRA_ACK;
		end
		// Unmapped ports stay released so another device may answer
		else if (rd && own && is_mapped(st_reg.addr))
		begin
			st_next.cyc = pbra_pkg::PBRA_READ;
		end
		else if (wr)
		begin
			st_next.cyc = pbra_pkg::PBRA_WRITE;
		end
		else
		begin
			st_next.cyc = pbra_pkg::PBRA_IDLE;
		end

		unique case (st_next.cyc)
			pbra_pkg::PBRA_READ:
			begin
				st_next.oe = 1'b1;
				st_next.dout = rd_mux;
			end
			pbra_pkg::PBRA_ACK:
			begin
				st_next.oe = 1'b1;
				st_next.dout = pbra_pkg::IRQ_VECTOR_BASE | {5'h00, irq_level_i};
			end
			pbra_pkg::PBRA_WRITE, pbra_pkg::PBRA_IDLE:
			begin
				st_next.oe = 1'b0;
				st_next.dout = pbra_pkg::BYTE_ZERO;
			end
		endcase

		// Commit on the trailing edge of write, data captured from the bus
		if (st_reg.wr_d && !wr && own)
		begin
			unique case (st_reg.addr)
				pbra_pkg::PORT_IRQ_MASK: st_next.mask = st_reg.din_s2;
				pbra_pkg::PORT_IRQ_CMD: st_next.tmr_ctl[0] = st_reg.din_s2[0];
				pbra_pkg::PORT_TMR_CTRL: st_next.tmr_ctl = st_reg.din_s2;
				pbra_pkg::PORT_SYS_B: st_next.sys_b = st_reg.din_s2;
				pbra_pkg::PORT_RTC_ADDR: st_next.rtc_idx = st_reg.din_s2[5:0];
				pbra_pkg::PORT_SYS_A: st_next.sys_a = st_reg.din_s2;
				pbra_pkg::PORT_SETUP: st_next.setup = st_reg.din_s2;
				pbra_pkg::PORT_CHAN_POS: st_next.chan_pos = st_reg.din_s2 & pbra_pkg::CHAN_POS_WR_MASK;
				pbra_pkg::PORT_CFG: st_next.cfg = st_reg.din_s2;
				default: st_next.cfg = st_reg.cfg;
			endcase
		end
	end

	// Timekeeping data goes straight to memory; index register steers it
	assign rtc_bus.we = st_reg.wr_d && !wr && rtc_data_hit;
	assign rtc_bus.addr = st_reg.rtc_idx;
	assign rtc_bus.wdata = st_reg.din_s2;

	// Logic reset clears control state; timekeeping memory is left alone
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || st_reg.lrst_s2)
		begin
			st_reg <= '0;
			st_reg.strb_s1 <= 2'b10;
			st_reg.strb_s2 <= 2'b10;
			st_reg.cmd_s1 <= 2'b11;
			st_reg.cmd_s2 <= 2'b11;
			st_reg.ack_s1 <= 1'b1;
			st_reg.ack_s2 <= 1'b1;
			st_reg.mst_s1 <= 1'b1;
			st_reg.mst_s2 <= 1'b1;
			st_reg.strb_d <= 1'b1;
			st_reg.ack_d <= 1'b1;
			st_reg.onboard_peripheral_select_n_n <= 1'b1;
			st_reg.qstrb_n <= 1'b1;
			st_reg.sys_b <= pbra_pkg::SYS_B_RST;
			st_reg.sys_a <= pbra_pkg::SYS_A_RST;
			st_reg.setup <= pbra_pkg::SETUP_RST;
			st_reg.chan_pos <= pbra_pkg::CHAN_POS_RST;
			st_reg.cfg <= pbra_pkg::CFG_RST;
			// The reset synchroniser keeps sampling, or the reset would never end
			st_reg.lrst_s1 <= logic_reset_input_i;
			st_reg.lrst_s2 <= st_reg.lrst_s1;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign peripheral_data_bus_o = st_reg.dout;
	assign peripheral_data_bus_oe_o = st_reg.oe;
	assign onboard_peripheral_select_n_o = st_reg.onboard_peripheral_select_n_n;
	assign qualified_latch_strobe_n_o = st_reg.qstrb_n;
	assign par_irq_clear_o = st_reg.par_clr;
	assign irq_mask_o = st_reg.mask;
	assign sys_b_o = st_reg.sys_b;
	assign sys_a_o = st_reg.sys_a;
	assign setup_o = st_reg.setup;
	assign chan_pos_o = st_reg.chan_pos;
	assign cfg_o = st_reg.cfg;

endmodule : pbra_port

// ---- pbra_port_sva.sv ----
// Checker for the peripheral bus port; it sees the top module's pins only.
// Assumes the bench holds address, level and commands steady through a bus cycle.
module pbra_port_sva (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic logic_reset_input_i,
	// Bus pins
	input wire logic [9:0] latched_peripheral_address_i,
	input wire logic [5:0] upper_address_i,
	input wire logic address_latch_strobe_n_i,
	input wire logic io_read_cmd_n_i,
	input wire logic io_write_cmd_n_i,
	input wire logic irq_ack_n_i,
	input wire logic ext_master_n_i,
	input wire logic [2:0] irq_level_i,
	input wire logic [7:0] peripheral_data_bus_o,
	input wire logic peripheral_data_bus_oe_o,
	// Decodes
	input wire logic onboard_peripheral_select_n_o,
	input wire logic par_irq_clear_o,
	input wire logic [7:0] setup_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Saturating counts of cycles since a read/acknowledge or a strobe was low
	logic [2:0] rdq_reg = 3'h7;
	logic [2:0] stq_reg = 3'h7;
	always_ff @(posedge core_clk_i)
	begin
		rdq_reg <= (io_read_cmd_n_i && irq_ack_n_i) ? rdq_reg + 3'(rdq_reg != 3'h7) : 3'h0;
		stq_reg <= address_latch_strobe_n_i ? stq_reg + 3'(stq_reg != 3'h7) : 3'h0;
	end
	property p_rd; peripheral_data_bus_oe_o |-> rdq_reg < 3'h5; endproperty
	a_rd: assert property (p_rd) else $error("bus driven outside a read");
	property p_wr;
		(!io_write_cmd_n_i && io_read_cmd_n_i && irq_ack_n_i)[*5] |-> !peripheral_data_bus_oe_o;
	endproperty
	a_wr: assert property (p_wr) else $error("bus driven during a write");
	property p_both;
		(!io_write_cmd_n_i && !io_read_cmd_n_i && irq_ack_n_i)[*5] |-> !peripheral_data_bus_oe_o;
	endproperty
	a_both: assert property (p_both) else $error("bus driven with both commands");
	property p_sel;
		(upper_address_i == 6'h00 && !address_latch_strobe_n_i)[*5] |-> !onboard_peripheral_select_n_o;
	endproperty
	a_sel: assert property (p_sel) else $error("select missing for zero upper address");
	property p_master;
		(!ext_master_n_i && !io_read_cmd_n_i && irq_ack_n_i
			&& latched_peripheral_address_i[9:1] != 9'h010)[*5] |-> !peripheral_data_bus_oe_o;
	endproperty
	a_master: assert property (p_master) else $error("master reached a blocked port");
	property p_clr; par_irq_clear_o |-> stq_reg < 3'h5 ##1 !par_irq_clear_o; endproperty
	a_clr: assert property (p_clr) else $error("clear pulse without strobe");
	property p_vec;
		(!irq_ack_n_i && io_read_cmd_n_i)[*5] ##0 peripheral_data_bus_oe_o
			|-> peripheral_data_bus_o == (pbra_pkg::IRQ_VECTOR_BASE | {5'h00, irq_level_i});
	endproperty
	a_vec: assert property (p_vec) else $error("wrong vector byte");
	property p_lrst;
		logic_reset_input_i[*3] |=> !peripheral_data_bus_oe_o && setup_o == pbra_pkg::SETUP_RST;
	endproperty
	a_lrst: assert property (p_lrst) else $error("logic reset not applied");
	cover property (par_irq_clear_o);
	cover property (!irq_ack_n_i && peripheral_data_bus_oe_o);
	cover property (!ext_master_n_i && !io_write_cmd_n_i);
endmodule : pbra_port_sva

bind pbra_port pbra_port_sva chk_u (.core_clk_i, .rst_n_i, .logic_reset_input_i,
	.latched_peripheral_address_i, .upper_address_i, .address_latch_strobe_n_i,
	.io_read_cmd_n_i, .io_write_cmd_n_i, .irq_ack_n_i, .ext_master_n_i, .irq_level_i,
	.peripheral_data_bus_o, .peripheral_data_bus_oe_o, .onboard_peripheral_select_n_o,
	.par_irq_clear_o, .setup_o);

// ---- pbra_host_model.sv ----
// Host bus controller model: strobes addresses, issues commands and acknowledges.
// Assumes calls start just after a falling clock edge.
module pbra_host_model (
	// Clock
	input wire logic core_clk_i,
	// Device side
	input wire logic [7:0] dev_dout_i,
	input wire logic dev_oe_i,
	output logic [7:0] bus_o,
	output logic [9:0] addr_o = 10'h000,
	output logic [5:0] upper_o = 6'h00,
	output logic strobe_n_o = 1'b1,
	output logic rd_n_o = 1'b1,
	output logic wr_n_o = 1'b1,
	output logic ack_n_o = 1'b1
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] wdata = 8'h00;
	logic wdrv = 1'b0;
	logic [7:0] idle_pat = 8'h5a;
	// A released bus must not look like it still holds the last byte
	always @(posedge core_clk_i) idle_pat <= ~idle_pat;
	assign bus_o = dev_oe_i ? dev_dout_i : (wdrv ? wdata : idle_pat);
	task automatic wait_n(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask : wait_n
	// Kind 0 reads, 1 writes, 2 raises both commands
	task automatic cycle(input int kind, input logic [5:0] up, input logic [9:0] a,
		input logic [7:0] v, output logic oe, output logic [7:0] q);
		addr_o = a;
		upper_o = up;
		strobe_n_o = 1'b0;
		wait_n(6);
		strobe_n_o = 1'b1;
		wait_n(2);
		wdata = v;
		wdrv = kind != 0;
		rd_n_o = kind == 1;
		wr_n_o = kind == 0;
		wait_n(6);
		oe = dev_oe_i;
		q = bus_o;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		wait_n(6);
		wdrv = 1'b0;
	endtask : cycle
	task automatic ack_pair(output logic oe, output logic [7:0] q);
		repeat (2)
		begin
			ack_n_o = 1'b0;
			wait_n(6);
			oe = dev_oe_i;
			q = bus_o;
			ack_n_o = 1'b1;
			wait_n(6);
		end
	endtask : ack_pair
endmodule : pbra_host_model

// ---- test_pbra_port.sv ----
// Bench for the peripheral bus port: host model, reference model and comparisons.
// Assumes the port map and reset values held in pbra_pkg.
module test_pbra_port;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic logic_reset_input_i = 1'b0;
	logic ext_master_n_i = 1'b1;
	logic wdt_timeout_i = 1'b0;
	logic [2:0] irq_level_i = 3'h0;
	logic [7:0] src [5] = '{default: 8'h00};
	logic [7:0] bus, dout, mask, sys_b, sys_a, setup, chan, cfg, q, d;
	logic [9:0] addr;
	logic [5:0] upper;
	logic stb_n, rd_n, wr_n, ack_n, oe, sel_n, got_oe, qs_n, pclr;
	logic stb_q = 1'b1;
	int n_stb = 0;
	int n_fall = 0;
	int n_qs = 0;
	int n_clr = 0;
	logic [7:0] mdl [1024];
	logic [9:0] wport [5] = '{10'h021, 10'h061, 10'h094, 10'h096, 10'h102};
	logic [9:0] rport [8] = '{10'h020, 10'h021, 10'h040, 10'h042, 10'h044, 10'h092, 10'h096,
		10'h102};
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	always #(pbra_pkg::CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;
	pbra_port dut_u (.core_clk_i, .rst_n_i, .logic_reset_input_i,
		.peripheral_data_bus_i(bus), .peripheral_data_bus_o(dout),
		.peripheral_data_bus_oe_o(oe), .latched_peripheral_address_i(addr),
		.upper_address_i(upper), .address_latch_strobe_n_i(stb_n),
		.io_read_cmd_n_i(rd_n), .io_write_cmd_n_i(wr_n), .irq_ack_n_i(ack_n),
		.ext_master_n_i, .irq_request_i(src[0]), .irq_in_service_i(src[1]),
		.tmr_ch0_i(src[2]), .tmr_ch2_i(src[3]), .tmr_ch3_i(src[4]),
		.irq_level_i, .wdt_timeout_i, .onboard_peripheral_select_n_o(sel_n),
		.qualified_latch_strobe_n_o(qs_n), .par_irq_clear_o(pclr), .irq_mask_o(mask),
		.sys_b_o(sys_b), .sys_a_o(sys_a), .setup_o(setup), .chan_pos_o(chan), .cfg_o(cfg));
	pbra_host_model host_u (.core_clk_i, .dev_dout_i(dout), .dev_oe_i(oe), .bus_o(bus),
		.addr_o(addr), .upper_o(upper), .strobe_n_o(stb_n), .rd_n_o(rd_n),
		.wr_n_o(wr_n), .ack_n_o(ack_n));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [9:0] a, input logic [7:0] v);
		host_u.cycle(1, 6'h00, a, v, got_oe, q);
		mdl[a] = v;
	endtask : wr
	task automatic rd(input logic [9:0] a);
		host_u.cycle(0, 6'h00, a, 8'h00, got_oe, q);
	endtask : rd
	function automatic logic [7:0] exp_rd(input logic [9:0] a);
		case (a)
			10'h020: return src[0];
			10'h040: return src[2];
			10'h042: return src[3];
			10'h044: return src[4];
			10'h092: return mdl[a] | 8'h24 | {3'h0, wdt_timeout_i, 4'h0};
			10'h096: return (mdl[a] & 8'h8f) | 8'h70;
			default: return mdl[a];
		endcase
	endfunction : exp_rd
	always @(posedge core_clk_i)
	begin
		cyc++;
		// Strobe cycles and strobe assertions with a zero upper address
		if (!stb_n && upper == 6'h00)
			n_stb++;
		if (!stb_n && stb_q && upper == 6'h00)
			n_fall++;
		stb_q = stb_n;
		if (cyc == 5000)
		begin
			err_count++;
			$display("ERROR %0t: run did not finish", $time);
			wrap_up();
		end
	end
	// Registered outputs are counted where they are settled
	always @(negedge core_clk_i)
	begin
		if (qs_n === 1'b0)
			n_qs++;
		if (pclr === 1'b1)
			n_clr++;
	end
	initial
	begin
		void'($urandom(18));
		repeat (5) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rst_n_i = 1'b1;
		chk(setup, pbra_pkg::SETUP_RST);
		chk({7'h00, oe}, 8'h00);
		foreach (src[i]) src[i] = 8'($urandom);
		irq_level_i = 3'($urandom);
		wdt_timeout_i = 1'($urandom);
		foreach (wport[i]) wr(wport[i], 8'($urandom));
		wr(10'h092, 8'($urandom) & 8'hca);
		chk(mask, mdl[10'h021]);
		chk(sys_b, mdl[10'h061]);
		chk(setup, mdl[10'h094]);
		chk(chan, mdl[10'h096] & 8'h8f);
		chk(cfg, mdl[10'h102]);
		chk(sys_a, mdl[10'h092]);
		$display("write test done");
		foreach (rport[i])
		begin
			rd(rport[i]);
			chk({7'h00, got_oe}, 8'h01);
			chk(q, exp_rd(rport[i]));
		end
		rd(10'h061);
		chk({7'h00, got_oe}, 8'h01);
		chk(q, mdl[10'h061]);
		chk({7'h00, sel_n}, 8'h00);
		rd(10'h0a0);
		chk({7'h00, got_oe}, 8'h00);
		$display("read test done");
		ext_master_n_i = 1'b0;
		host_u.cycle(1, 6'h00, 10'h061, ~mdl[10'h061], got_oe, q);
		rd(10'h092);
		chk({7'h00, got_oe}, 8'h00);
		wr(10'h021, ~mdl[10'h021]);
		rd(10'h021);
		chk({7'h00, got_oe}, 8'h01);
		chk(q, mdl[10'h021]);
		ext_master_n_i = 1'b1;
		chk(sys_b, mdl[10'h061]);
		chk(mask, mdl[10'h021]);
		host_u.cycle(1, 6'h20, 10'h102, ~mdl[10'h102], got_oe, q);
		host_u.cycle(0, 6'h01, 10'h102, 8'h00, got_oe, q);
		chk({7'h00, got_oe}, 8'h00);
		chk({7'h00, sel_n}, 8'h01);
		host_u.cycle(2, 6'h00, 10'h102, ~mdl[10'h102], got_oe, q);
		chk({7'h00, got_oe}, 8'h00);
		chk(cfg, mdl[10'h102]);
		chk(8'(n_qs), 8'(n_stb));
		chk(8'(n_clr), 8'(n_fall));
		$display("refusal test done");
		host_u.ack_pair(got_oe, q);
		chk({7'h00, got_oe}, 8'h01);
		chk(q, pbra_pkg::IRQ_VECTOR_BASE | {5'h00, irq_level_i});
		d = 8'($urandom);
		wr(10'h070, 8'($urandom) & 8'h3f);
		wr(10'h071, d);
		logic_reset_input_i = 1'b1;
		repeat (4) @(negedge core_clk_i);
		logic_reset_input_i = 1'b0;
		// Let the synchronised reset drain before the next bus cycle
		repeat (3) @(negedge core_clk_i);
		chk(setup, pbra_pkg::SETUP_RST);
		chk(sys_b, pbra_pkg::SYS_B_RST);
		wr(10'h070, mdl[10'h070]);
		rd(10'h071);
		chk(q, d);
		$display("vector and timekeeping test done");
		wrap_up();
	end
endmodule : test_pbra_port
